/* File: core/ssr_map.vh */
`ifndef SSR_MAP_VH
`define SSR_MAP_VH

// ****************************************************************
// Display code groups (virtual node addresses)
// ****************************************************************
`define SSR_GRP_LOGIC        7'd90
`define SSR_GRP_SCANNER      7'd91
`define SSR_GRP_CANHW        7'd96
`define SSR_GRP_NETACC       7'd97
`define SSR_GRP_THREAD       7'd98
`define SSR_NODE_LAST        7'd63

// ****************************************************************
// Display codes
// ****************************************************************
`define SSR_LOG_SEMA         7'd1
`define SSR_LOG_DISCARD      7'd2
`define SSR_LOG_INDEX        7'd3
`define SSR_SCN_OVERRUN      7'd1
`define SSR_SCN_DUP_RSP      7'd2
`define SSR_SCN_DUP_REQ      7'd3
`define SSR_CAN_BUS_OFF      7'd1
`define SSR_CAN_NO_PWR       7'd2
`define SSR_CAN_BAD_PWR      7'd3
`define SSR_CAN_WARN         7'd4
`define SSR_CAN_NO_ACK       7'd13
`define SSR_NA_DISC          7'd0
`define SSR_NA_FAULT         7'd1
`define SSR_NA_OFFLINE       7'd2
`define SSR_NA_DUP_RSP       7'd3
`define SSR_NA_DUP_REQ       7'd4
`define SSR_NA_BUS_OFF       7'd5
`define SSR_NA_PWRUP         7'd6
`define SSR_NA_JUST_RST      7'd7
`define SSR_NA_DUP1_SEND     7'd8
`define SSR_NA_DUP1_WAIT     7'd9
`define SSR_NA_DUP2_SEND     7'd10
`define SSR_NA_DUP2_WAIT     7'd11
`define SSR_NA_ONLINE_A      7'd14
`define SSR_NA_ONLINE_B      7'd15
`define SSR_NA_SCANNING      7'd16
`define SSR_NA_RST_REQ       7'd17
`define SSR_NA_RST_BUSY      7'd18
`define SSR_THR_INIT         7'd1
`define SSR_THR_CFG_CHECK    7'd3
`define SSR_THR_STOPPED      7'd13

// ****************************************************************
// Health word bit positions (bit 1 of the word is index 0)
// ****************************************************************
`define SSR_B_MODULE_FAIL    0
`define SSR_B_SCANNER_FAIL   1
`define SSR_B_CFG_REQUIRED   2
`define SSR_B_CFG_ERROR      3
`define SSR_B_OFFLINE        4
`define SSR_B_SCAN_STOPPED   5
`define SSR_B_CYCLE_START    6
`define SSR_B_NET_ERROR      7
`define SSR_B_DEV_OFFLINE    8
`define SSR_B_BLOCK_ERROR    9
`define SSR_B_OVERRUN        10
`define SSR_B_RESERVED       11
`define SSR_F_CNT_LSB        12
`define SSR_F_CODE_LSB       8
`define SSR_HEALTH_RESET     16'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define SSR_CLK_HZ           250000000
`define SSR_BEAT_MS          1000
`define SSR_BEAT_CYCLES      (`SSR_CLK_HZ / 1000 * `SSR_BEAT_MS)

`endif

/* File: core/ssr_status.v */
`timescale 1ns/1ps
`include "ssr_map.vh"

module ssr_status #(
    parameter BEAT_CYCLES = `SSR_BEAT_CYCLES
) (
    input  wire        clk_sys,
    input  wire        rstn,
    input  wire        clk_en,
    // Supervisory and scanner processor condition levels.
    input  wire        module_fatal,
    input  wire [7:0]  module_fatal_code,
    input  wire        scanner_fatal,
    input  wire        program_valid,
    input  wire        config_missing,
    input  wire        config_loaded_ok,
    input  wire        config_bad,
    input  wire        link_up,
    input  wire        scanning,
    input  wire        net_blocked,
    input  wire        node_unconnected,
    input  wire        block_xfer_fail,
    input  wire        scan_interval_long,
    // Event pulses.
    input  wire        scan_start_req,
    input  wire        polls_pending,
    input  wire        plc_scan_pulse,
    input  wire        dup_rsp_event,
    input  wire        dup_req_event,
    input  wire        sema_locked,
    input  wire        msgs_discarded,
    input  wire        display_index_over,
    // CAN controller conditions.
    input  wire        can_bus_off,
    input  wire        error_rate_warning,
    input  wire        no_ack_fault,
    input  wire        net_power_absent,
    input  wire        net_power_range,
    // Network access sequence and thread state.
    input  wire [4:0]  netacc_state,
    input  wire [1:0]  thread_state,
    // Display group select.
    input  wire [6:0]  display_group,
    output reg  [6:0]  display_node_q,
    output reg  [6:0]  display_code_q,
    output reg  [15:0] module_health_word_q,
    output wire        scan_start_grant,
    output reg         scan_overrun_q
);

    // ****************************************************************
    // Network access sequence states
    // ****************************************************************
    localparam NA_PWRUP   = 5'd0;
    localparam NA_RST     = 5'd1;
    localparam NA_D1S     = 5'd2;
    localparam NA_D1W     = 5'd3;
    localparam NA_D2S     = 5'd4;
    localparam NA_D2W     = 5'd5;
    localparam NA_ONA     = 5'd6;
    localparam NA_ONB     = 5'd7;
    localparam NA_SCAN    = 5'd8;
    localparam NA_DISC    = 5'd9;
    localparam NA_FAULT   = 5'd10;
    localparam NA_OFFL    = 5'd11;
    localparam NA_DUPRSP  = 5'd12;
    localparam NA_DUPREQ  = 5'd13;
    localparam NA_BUSOFF  = 5'd14;
    localparam NA_RSTREQ  = 5'd15;
    localparam NA_RSTBUSY = 5'd16;

    localparam TH_INIT    = 2'd0;
    localparam TH_CHECK   = 2'd1;
    localparam TH_STOP    = 2'd2;

    localparam [31:0] BEAT_LAST = BEAT_CYCLES - 1;

    reg  [31:0] beat_cnt_q;
    reg  [3:0]  alive_cnt_q;
    reg         cycle_start_pulse_q;
    reg         cycle_seen_plc_q;
    reg         cfg_req_q;
    reg  [1:0]  scn_err_q;
    reg  [1:0]  log_err_q;
    reg  [6:0]  code_d;
    reg  [15:0] word_d;
    wire        online;

    assign online = (netacc_state == NA_ONA) || (netacc_state == NA_ONB) ||
                    (netacc_state == NA_SCAN);

    // A scan start is held back while responses of the last scan remain.
    assign scan_start_grant = scan_start_req && !polls_pending;

    // ****************************************************************
    // Heartbeat counter
    // ****************************************************************
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            beat_cnt_q  <= 32'h0000_0000;
            alive_cnt_q <= 4'h0;
        end else if (clk_en) begin
            if (beat_cnt_q >= BEAT_LAST) begin
                beat_cnt_q  <= 32'h0000_0000;
                alive_cnt_q <= alive_cnt_q + 4'h1;
            end else begin
                beat_cnt_q <= beat_cnt_q + 32'h0000_0001;
            end
        end
    end

    // ****************************************************************
    // Begin-of-scan flag and event latches
    // ****************************************************************
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cycle_start_pulse_q <= 1'b0;
            cycle_seen_plc_q    <= 1'b0;
            cfg_req_q           <= 1'b0;
            scn_err_q           <= 2'd0;
            log_err_q           <= 2'd0;
            scan_overrun_q      <= 1'b0;
        end else if (clk_en) begin
            // Set on scan start; cleared on the second PLC scan boundary.
            if (scan_start_grant) begin
                cycle_start_pulse_q <= 1'b1;
                cycle_seen_plc_q    <= 1'b0;
            end else if (plc_scan_pulse && cycle_start_pulse_q) begin
                if (cycle_seen_plc_q) begin
                    cycle_start_pulse_q <= 1'b0;
                end
                cycle_seen_plc_q <= ~cycle_seen_plc_q;
            end
            // Configuration required holds until a clean download, or until program_valid drops.
            if (!program_valid) begin
                cfg_req_q <= 1'b0;
            end else if (config_missing) begin
                cfg_req_q <= 1'b1;
            end else if (config_loaded_ok && !config_bad) begin
                cfg_req_q <= 1'b0;
            end
            scan_overrun_q <= scan_start_req && polls_pending;
            if (scan_start_req && polls_pending) begin
                scn_err_q <= 2'd1;
            end else if (dup_rsp_event && online) begin
                scn_err_q <= 2'd2;
            end else if (dup_req_event && !online) begin
                scn_err_q <= 2'd3;
            end
            if (sema_locked) begin
                log_err_q <= 2'd1;
            end else if (msgs_discarded) begin
                log_err_q <= 2'd2;
            end else if (display_index_over) begin
                log_err_q <= 2'd3;
            end
        end
    end

    // ****************************************************************
    // Display code selection
    // ****************************************************************
    always @* begin
        code_d = 7'd0;
        case (display_group)
            `SSR_GRP_LOGIC: begin
                case (log_err_q)
                    2'd1:    code_d = `SSR_LOG_SEMA;
                    2'd2:    code_d = `SSR_LOG_DISCARD;
                    2'd3:    code_d = `SSR_LOG_INDEX;
                    default: code_d = 7'd0;
                endcase
            end
            `SSR_GRP_SCANNER: begin
                case (scn_err_q)
                    2'd1:    code_d = `SSR_SCN_OVERRUN;
                    2'd2:    code_d = `SSR_SCN_DUP_RSP;
                    2'd3:    code_d = `SSR_SCN_DUP_REQ;
                    default: code_d = 7'd0;
                endcase
            end
            `SSR_GRP_CANHW: begin
                if (can_bus_off) begin
                    code_d = `SSR_CAN_BUS_OFF;
                end else if (net_power_absent) begin
                    code_d = `SSR_CAN_NO_PWR;
                end else if (net_power_range) begin
                    code_d = `SSR_CAN_BAD_PWR;
                end else if (no_ack_fault) begin
                    code_d = `SSR_CAN_NO_ACK;
                end else if (error_rate_warning) begin
                    code_d = `SSR_CAN_WARN;
                end
            end
            `SSR_GRP_NETACC: begin
                case (netacc_state)
                    NA_PWRUP:   code_d = `SSR_NA_PWRUP;
                    NA_RST:     code_d = `SSR_NA_JUST_RST;
                    NA_D1S:     code_d = `SSR_NA_DUP1_SEND;
                    NA_D1W:     code_d = `SSR_NA_DUP1_WAIT;
                    NA_D2S:     code_d = `SSR_NA_DUP2_SEND;
                    NA_D2W:     code_d = `SSR_NA_DUP2_WAIT;
                    NA_ONA:     code_d = `SSR_NA_ONLINE_A;
                    NA_ONB:     code_d = `SSR_NA_ONLINE_B;
                    NA_SCAN:    code_d = `SSR_NA_SCANNING;
                    NA_DISC:    code_d = `SSR_NA_DISC;
                    NA_FAULT:   code_d = `SSR_NA_FAULT;
                    NA_OFFL:    code_d = `SSR_NA_OFFLINE;
                    NA_DUPRSP:  code_d = `SSR_NA_DUP_RSP;
                    NA_DUPREQ:  code_d = `SSR_NA_DUP_REQ;
                    NA_BUSOFF:  code_d = `SSR_NA_BUS_OFF;
                    NA_RSTREQ:  code_d = `SSR_NA_RST_REQ;
                    NA_RSTBUSY: code_d = `SSR_NA_RST_BUSY;
                    default:    code_d = `SSR_NA_DISC;
                endcase
            end
            `SSR_GRP_THREAD: begin
                case (thread_state)
                    TH_INIT:  code_d = `SSR_THR_INIT;
                    TH_CHECK: code_d = `SSR_THR_CFG_CHECK;
                    TH_STOP:  code_d = `SSR_THR_STOPPED;
                    default:  code_d = 7'd0;
                endcase
            end
            default: begin
                code_d = 7'd0;
            end
        endcase
    end

    // ****************************************************************
    // Health word assembly
    // ****************************************************************
    always @* begin
        word_d = `SSR_HEALTH_RESET;
        word_d[`SSR_B_MODULE_FAIL]  = module_fatal;
        word_d[`SSR_B_SCANNER_FAIL] = scanner_fatal;
        word_d[`SSR_B_CFG_REQUIRED] = cfg_req_q && program_valid;
        word_d[`SSR_B_CFG_ERROR]    = !program_valid || config_bad;
        word_d[`SSR_B_OFFLINE]      = !link_up;
        word_d[`SSR_B_SCAN_STOPPED] = !scanning;
        word_d[`SSR_B_CYCLE_START]  = cycle_start_pulse_q;
        word_d[`SSR_B_NET_ERROR]    = net_blocked;
        if (module_fatal) begin
            word_d[15:8] = module_fatal_code;
        end else begin
            word_d[`SSR_B_DEV_OFFLINE] = node_unconnected;
            word_d[`SSR_B_BLOCK_ERROR] = block_xfer_fail;
            word_d[`SSR_B_OVERRUN]     = scan_interval_long;
            word_d[`SSR_B_RESERVED]    = 1'b0;
            word_d[15:12]              = alive_cnt_q;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            display_node_q       <= 7'd0;
            display_code_q       <= 7'd0;
            module_health_word_q <= `SSR_HEALTH_RESET;
        end else if (clk_en) begin
            display_node_q       <= display_group;
            display_code_q       <= code_d;
            module_health_word_q <= word_d;
        end
    end

endmodule // ssr_status

/* File: tb/ssr_status_properties.sv */
`timescale 1ns/1ps
module ssr_status_properties #(
    parameter BEAT_CYCLES = 16
) (
    input wire        clk_sys,
    input wire        rstn,
    input wire        clk_en,
    input wire        module_fatal,
    input wire [7:0]  module_fatal_code,
    input wire        link_up,
    input wire        scanning,
    input wire        scan_start_req,
    input wire        polls_pending,
    input wire [6:0]  display_group,
    input wire [6:0]  display_node_q,
    input wire [15:0] module_health_word_q,
    input wire        scan_start_grant,
    input wire        scan_overrun_q
);
    wire [15:0] w;
    assign w = module_health_word_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_grant_from_req: assert property (
        scan_start_grant == (scan_start_req && !polls_pending))
        else $error("grant disagrees with request");
    a_overrun_flag_set: assert property (
        clk_en && scan_start_req && polls_pending |=> scan_overrun_q)
        else $error("overrun flag missing");
    a_fatal_code_shown: assert property (
        clk_en && module_fatal |=> w[0] && w[15:8] == $past(module_fatal_code))
        else $error("fatal code not shown");
    a_reserved_bit_zero: assert property (
        clk_en && !module_fatal |=> !w[11])
        else $error("reserved bit set");
    a_link_scan_flags: assert property (
        clk_en |=> w[5:4] == ~{$past(scanning), $past(link_up)})
        else $error("offline or stopped flag wrong");
    a_group_echo: assert property (
        clk_en |=> display_node_q == $past(display_group))
        else $error("group address not echoed");
    a_cycle_start_set: assert property (
        clk_en && scan_start_grant ##1 clk_en |=> w[6])
        else $error("scan start bit not set");
    a_beat_step_one: assert property (
        !module_fatal [*2] |=> w[15:12] inside {$past(w[15:12]), $past(w[15:12]) + 4'h1})
        else $error("heartbeat jumped");
    cover property (scan_overrun_q);
    cover property (w[6]);
    cover property (module_fatal ##1 w[0]);
endmodule // ssr_status_properties

/* File: tb/ssr_plc_model.sv */
`timescale 1ns/1ps
module ssr_plc_model #(
    parameter int PERIOD = 6
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        run,
    input  wire logic [15:0] module_health_word_q,
    output logic             plc_scan_pulse,
    output logic             data_ok
);
    int cnt;
    // A scan boundary is marked once every PERIOD cycles while the program runs.
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt <= 0;
            plc_scan_pulse <= 1'b0;
        end else begin
            cnt <= (run && cnt < PERIOD - 1) ? cnt + 1 : 0;
            plc_scan_pulse <= run && cnt == PERIOD - 1;
        end
    end
    // Input data is trusted only while no failure, offline or stopped flag is up.
    assign data_ok = ~|(module_health_word_q & 16'h0033);
endmodule // ssr_plc_model

/* File: tb/scanner_status_reporting_tb.sv */
`timescale 1ns/1ps
module scanner_status_reporting_tb;
    localparam int BEAT = 16;
    logic clk_sys = 0, rstn = 0, clk_en = 1, run = 0, module_fatal = 0, scanner_fatal = 0;
    logic program_valid = 1, config_missing = 0, config_loaded_ok = 0, config_bad = 0;
    logic link_up = 1, scanning = 1, net_blocked = 0, node_unconnected = 0, block_xfer_fail = 0;
    logic scan_interval_long = 0, scan_start_req = 0, polls_pending = 0, dup_rsp_event = 0;
    logic dup_req_event = 0, sema_locked = 0, msgs_discarded = 0, display_index_over = 0;
    logic can_bus_off = 0, error_rate_warning = 0, no_ack_fault = 0, net_power_absent = 0;
    logic net_power_range = 0, scan_start_grant, scan_overrun_q, plc_scan_pulse, data_ok;
    logic [7:0]  module_fatal_code = 8'h00;
    logic [4:0]  netacc_state = 5'h00;
    logic [1:0]  thread_state = 2'h0;
    logic [6:0]  display_group = 7'h00, display_node_q, display_code_q;
    logic [15:0] module_health_word_q;
    logic [3:0]  c;
    int n_mismatch = 0, checks = 0, cyc = 0, k;
    logic [20:0] rows [5] = '{{9'b000000000, 12'h038}, {9'b011111111, 12'h782},
        {9'b101110111, 12'h001}, {9'b001110100, 12'h100}, {9'b001110000, 12'h000}};
    logic [6:0] na [17] = '{7'h06, 7'h07, 7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0e, 7'h0f, 7'h10,
        7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h11, 7'h12};
    logic [6:0] th [4] = '{7'h01, 7'h03, 7'h0d, 7'h00};
    logic [6:0] cn [6] = '{7'h01, 7'h02, 7'h03, 7'h0d, 7'h04, 7'h01};
    ssr_status #(.BEAT_CYCLES(BEAT)) ssr_status_inst (
        .clk_sys, .rstn, .clk_en, .module_fatal, .module_fatal_code, .scanner_fatal,
        .program_valid, .config_missing, .config_loaded_ok, .config_bad, .link_up, .scanning,
        .net_blocked, .node_unconnected, .block_xfer_fail, .scan_interval_long, .scan_start_req,
        .polls_pending, .plc_scan_pulse, .dup_rsp_event, .dup_req_event, .sema_locked,
        .msgs_discarded, .display_index_over, .can_bus_off, .error_rate_warning, .no_ack_fault,
        .net_power_absent, .net_power_range, .netacc_state, .thread_state, .display_group,
        .display_node_q, .display_code_q, .module_health_word_q, .scan_start_grant,
        .scan_overrun_q);
    ssr_plc_model #(.PERIOD(6)) ssr_plc_model_inst (
        .clk_sys, .rstn, .run, .module_health_word_q, .plc_scan_pulse, .data_ok);
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic ev(ref logic s, input logic [6:0] e);
        s = 1;
        step(1);
        s = 0;
        step(1);
        chk("group code", display_code_q, e);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        step(20);
        chk("health word", module_health_word_q, 16'h0000);
        chk("overrun flag", scan_overrun_q, 1'b0);
        rstn = 1;
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            {module_fatal, scanner_fatal, program_valid, link_up, scanning, net_blocked,
             node_unconnected, block_xfer_fail, scan_interval_long} = rows[i][20:12];
            step(1);
            chk("flags", module_health_word_q[11:0] & 12'hfbb, rows[i][11:0]);
            chk("data ok", data_ok, ~|(rows[i][11:0] & 12'h033));
        end
        $display("test flag rows done");
        display_group = 7'h61;
        for (int i = 0; i < 17; i++) begin
            netacc_state = 5'(i);
            step(1);
            chk("access code", display_code_q, na[i]);
        end
        chk("node address", display_node_q, 7'h61);
        display_group = 7'h62;
        for (int i = 0; i < 4; i++) begin
            thread_state = 2'(i);
            step(1);
            chk("thread code", display_code_q, th[i]);
        end
        display_group = 7'h60;
        for (int i = 0; i < 6; i++) begin
            {can_bus_off, net_power_absent, net_power_range, no_ack_fault, error_rate_warning} =
                (i == 5) ? 5'h1f : 5'h10 >> i;
            step(1);
            chk("can code", display_code_q, cn[i]);
        end
        {can_bus_off, net_power_absent, net_power_range, no_ack_fault, error_rate_warning} = 0;
        display_group = 7'h5a;
        ev(display_index_over, 7'h03);
        ev(msgs_discarded, 7'h02);
        ev(sema_locked, 7'h01);
        display_group = 7'h5b;
        netacc_state = 5'd8;
        ev(dup_req_event, 7'h00);
        netacc_state = 5'd11;
        ev(dup_rsp_event, 7'h00);
        ev(dup_req_event, 7'h03);
        netacc_state = 5'd6;
        ev(dup_rsp_event, 7'h02);
        $display("test display codes done");
        polls_pending = 1;
        scan_start_req = 1;
        #1;
        chk("grant", scan_start_grant, 1'b0);
        step(1);
        scan_start_req = 0;
        polls_pending = 0;
        chk("overrun flag", scan_overrun_q, 1'b1);
        chk("scan start bit", module_health_word_q[6], 1'b0);
        step(1);
        chk("group code", display_code_q, 7'h01);
        scan_start_req = 1;
        #1;
        chk("grant", scan_start_grant, 1'b1);
        step(1);
        scan_start_req = 0;
        step(1);
        chk("scan start bit", module_health_word_q[6], 1'b1);
        run = 1;
        for (int p = 0; p < 2; p++) begin
            for (k = 0; k < 20 && !plc_scan_pulse; k++) step(1);
            step(2);
            chk("scan start bit", module_health_word_q[6], p == 0);
        end
        run = 0;
        $display("test scan start done");
        module_fatal = 1;
        module_fatal_code = 8'ha5;
        step(1);
        chk("fatal code", module_health_word_q[15:8], 8'ha5);
        chk("fatal bit", module_health_word_q[0], 1'b1);
        module_fatal = 0;
        config_missing = 1;
        step(1);
        config_missing = 0;
        step(1);
        chk("config bits", module_health_word_q[3:2], 2'b01);
        config_loaded_ok = 1;
        config_bad = 1;
        step(1);
        chk("config bits", module_health_word_q[3:2], 2'b11);
        config_bad = 0;
        step(2);
        chk("config bits", module_health_word_q[3:2], 2'b00);
        config_loaded_ok = 0;
        config_missing = 1;
        step(1);
        config_missing = 0;
        program_valid = 0;
        step(1);
        chk("config bits", module_health_word_q[3:2], 2'b10);
        program_valid = 1;
        clk_en = 0;
        link_up = 0;
        step(2);
        chk("frozen offline bit", module_health_word_q[4], 1'b0);
        clk_en = 1;
        step(1);
        chk("offline bit", module_health_word_q[4], 1'b1);
        link_up = 1;
        $display("test word fields done");
        c = module_health_word_q[15:12];
        for (k = 0; k < 40 && module_health_word_q[15:12] === c; k++) step(1);
        for (int i = 0; i < 17; i++) begin
            c = module_health_word_q[15:12];
            step(BEAT);
            chk("heartbeat", module_health_word_q[15:12], 4'(c + 4'h1));
        end
        $display("test heartbeat done");
        rstn = 0;
        step(1);
        chk("reset word", module_health_word_q, 16'h0000);
        chk("reset code", display_code_q, 7'h00);
        rstn = 1;
        step(2);
        chk("node address", display_node_q, 7'h5b);
        $display("test mid reset done");
        end_of_test();
    end
endmodule // scanner_status_reporting_tb
bind ssr_status ssr_status_properties #(.BEAT_CYCLES(BEAT_CYCLES)) ssr_status_properties_inst (
    .clk_sys, .rstn, .clk_en, .module_fatal, .module_fatal_code, .link_up, .scanning,
    .scan_start_req, .polls_pending, .display_group, .display_node_q, .module_health_word_q,
    .scan_start_grant, .scan_overrun_q);
